// File: hw/dps_pkg.sv
/*
  Shared constants and types of the dual pixel serializer control block.
  Assumes a single system clock domain; pins arrive unsynchronised.
*/
package dps_pkg;

  // ==========================================================
  // Operating modes
  localparam logic [1:0] DPS_MODE_SINGLE_IN_SINGLE_OUT = 2'h0;   // single_in_single_out
  localparam logic [1:0] DPS_MODE_SINGLE_IN_DUAL_OUT = 2'h1;   // single_in_dual_out
  localparam logic [1:0] DPS_MODE_DUAL_IN_DUAL_OUT = 2'h2;   // dual_in_dual_out
  localparam logic [1:0] DPS_MODE_RSVD = 2'h3;   // Not to be applied

  // ==========================================================
  // Pixel word layout
  localparam int DPS_WORD_W   = 28;
  localparam int DPS_LANES    = 4;
  localparam int DPS_BITS     = 7;
  localparam int DPS_HSYNC_POS = 18;
  localparam int DPS_VSYNC_POS = 19;
  localparam int DPS_DVAL_POS  = 20;
  localparam int DPS_PAIR_W   = 56;
  localparam logic [2:0] DPS_LAST_BIT = 3'h6;
  localparam logic [6:0] DPS_CLK_PATTERN = 7'h63;  // Clock lane shape per pixel slot

  // ==========================================================
  // Synchronised pin vector positions
  localparam int DPS_PIN_W      = 63;
  localparam int DPS_PIN_CLK    = 62;
  localparam int DPS_PIN_SLEEPN = 61;
  localparam int DPS_PIN_MODEHI = 60;
  localparam int DPS_PIN_MODELO = 59;
  localparam int DPS_PIN_EDGE   = 58;
  localparam int DPS_PIN_DEPTH  = 57;
  localparam int DPS_PIN_SWING  = 56;

  // ==========================================================
  // APB register map and reset values
  localparam logic [7:0]  DPS_REG_CTRL   = 8'h00;
  localparam logic [7:0]  DPS_REG_STATUS = 8'h04;
  localparam logic [7:0]  DPS_REG_PIXCNT = 8'h08;
  localparam logic [7:0]  DPS_REG_DROPS  = 8'h0C;
  localparam logic [31:0] DPS_CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] DPS_CNT_RST    = 16'h0000;
  localparam logic [15:0] DPS_CNT_ONE    = 16'h0001;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [DPS_WORD_W-1:0] a;
    logic [DPS_WORD_W-1:0] b;
  } dps_pair_t;

  typedef enum logic [1:0] {
    DPS_IDLE  = 2'b01,
    DPS_SHIFT = 2'b10
  } dps_ser_state_t;

endpackage

// File: hw/dps_pair_buf.sv
/*
  Two-entry valid/ready buffer for pixel pairs.
  Assumes both sides on the same clock; depth must be a power of two.
*/
module dps_pair_buf #(
  parameter int W     = 56,
  parameter int DEPTH = 2
) (
  input  wire logic         i_sys_clk,  // System clock
  input  wire logic         i_rst,      // Synchronous reset, high
  input  wire logic         i_valid,    // Fill side valid
  output logic              o_ready,    // Fill side ready
  input  wire logic [W-1:0] i_data,     // Fill side data
  output logic              o_valid,    // Drain side valid
  input  wire logic         i_ready,    // Drain side ready
  output logic [W-1:0]      o_data      // Drain side data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire           push = i_valid & o_ready;
  wire           pop  = o_valid & i_ready;

  // ==========================================================
  // Honest flags from the occupancy count
  assign o_ready = (count < (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];

  // Storage and pointers
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// File: hw/dps_serializer_ctl.sv
/*
  Dual pixel serializer control: strap decode, pixel capture on a sampled
  pixel clock, mode-dependent channel steering and 7:1 lane serialisation.
  Assumes pixel clock and straps come from pins; APB master on i_sys_clk.
*/
// Our own choices: register access over APB and the register addresses.
//
// Function
// [RULE_01] Two mode straps pick single/single, single/dual or dual/dual; code three reserved.
// [RULE_02] Pixels captured on falling pixel clock edge if strap low, rising if high.
// [RULE_03] Sleep while sleep input low; normal operation while high.
// [RULE_04] Colour-depth strap low gives 24-bit pixels, high gives 18-bit pixels.
// [RULE_05] Swing strap low gives reduced swing, high gives normal swing.
// [RULE_06] Hsync, vsync, data valid ride on bits 18, 19, 20 of channel A.
// [RULE_07] Source presents colour and control bits on input bits 27:21, 17:9, 8:0.
// [RULE_08] Each output channel drives four serial data lanes and one clock lane.
// [RULE_09] Single/single mode sends one pixel bank on channel A only.
// [RULE_10] Single/dual mode splits consecutive pixels across both channels at half rate.
// [RULE_11] Dual/dual mode maps input channels A and B onto outputs A and B.
// [RULE_12] Undriven controls read low: single/single, falling edge, sleep, 24-bit, low swing.
module dps_serializer_ctl
  import dps_pkg::*;
(
  input  wire logic                       i_sys_clk,          // System clock 200 MHz
  input  wire logic                       i_rst,              // Synchronous reset, high
  input  wire logic                       i_pixel_clk,        // Pixel clock pin
  input  wire logic                       i_op_mode_sel_lo,   // Mode strap low bit
  input  wire logic                       i_op_mode_sel_hi,   // Mode strap high bit
  input  wire logic                       i_capture_edge_sel, // 1 rising, 0 falling
  input  wire logic                       i_sleep_n,          // Low puts device to sleep
  input  wire logic                       i_color_depth_sel,  // 1 gives 18-bit colour
  input  wire logic                       i_out_swing_sel,    // 1 gives normal swing
  input  wire logic [dps_pkg::DPS_WORD_W-1:0] i_chan_a_pixel_in, // Channel A word
  input  wire logic [dps_pkg::DPS_WORD_W-1:0] i_chan_b_pixel_in, // Channel B word
  output logic [dps_pkg::DPS_LANES-1:0]   o_chan_a_ser_lane,  // Channel A data lanes
  output logic                            o_chan_a_ser_clk,   // Channel A clock lane
  output logic [dps_pkg::DPS_LANES-1:0]   o_chan_b_ser_lane,  // Channel B data lanes
  output logic                            o_chan_b_ser_clk,   // Channel B clock lane
  output logic                            o_swing_normal,     // Driver swing level
  output logic                            o_active,           // Datapath awake
  input  wire logic                       i_psel,             // APB select
  input  wire logic                       i_penable,          // APB enable
  input  wire logic                       i_pwrite,           // APB write
  input  wire logic [7:0]                 i_paddr,            // APB byte address
  input  wire logic [31:0]                i_pwdata,           // APB write data
  output logic [31:0]                     o_prdata,           // APB read data
  output logic                            o_pready,           // APB ready
  output logic                            o_pslverr           // APB error
);

  // ==========================================================
  // Pin synchroniser: three stages, change accepted when 2 and 3 agree
  logic [DPS_PIN_W-1:0] sync1;
  logic [DPS_PIN_W-1:0] sync2;
  logic [DPS_PIN_W-1:0] sync3;
  logic [DPS_PIN_W-1:0] filt;
  logic                 clk_prev;
  wire  [DPS_PIN_W-1:0] pins_raw = {i_pixel_clk, i_sleep_n, i_op_mode_sel_hi,
                                    i_op_mode_sel_lo, i_capture_edge_sel,
                                    i_color_depth_sel, i_out_swing_sel,
                                    i_chan_a_pixel_in, i_chan_b_pixel_in};
  wire  [DPS_PIN_W-1:0] agree    = ~(sync2 ^ sync3);
  wire  [DPS_PIN_W-1:0] next_filt = (sync2 & agree) | (filt & ~agree);

  // Filtered value starts low, as pulled-down pins would read
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sync1    <= '0;
      sync2    <= '0;
      sync3    <= '0;
      filt     <= '0;  // RULE_12
      clk_prev <= 1'b0;
    end
    else
    begin
      sync1    <= pins_raw;
      sync2    <= sync1;
      sync3    <= sync2;
      filt     <= next_filt;
      clk_prev <= filt[DPS_PIN_CLK];
    end
  end

  // ==========================================================
  // Strap decode
  logic       soft_sleep;
  wire  [1:0] mode       = {filt[DPS_PIN_MODEHI], filt[DPS_PIN_MODELO]};  // RULE_01
  wire        mode_rsvd  = (mode == DPS_MODE_RSVD);                        // RULE_01
  wire        mode_single_in_dual_out  = (mode == DPS_MODE_SINGLE_IN_DUAL_OUT);
  wire        mode_dual_in_dual_out  = (mode == DPS_MODE_DUAL_IN_DUAL_OUT);
  wire        mode_single_in_single_out  = ~mode_single_in_dual_out & ~mode_dual_in_dual_out;  // Reserved falls back to single
  wire        edge_rise  = filt[DPS_PIN_EDGE];
  wire        depth_18   = filt[DPS_PIN_DEPTH];
  wire        active     = filt[DPS_PIN_SLEEPN] & ~soft_sleep;              // RULE_03
  wire        dp_rst     = i_rst | ~active;                                 // RULE_03
  assign o_active = active;
  wire [DPS_WORD_W-1:0] pix_a = filt[DPS_PAIR_W-1:DPS_WORD_W];
  wire [DPS_WORD_W-1:0] pix_b = filt[DPS_WORD_W-1:0];

  // ==========================================================
  // Capture strobe from sampled pixel clock edges
  wire pclk_rise = filt[DPS_PIN_CLK] & ~clk_prev;
  wire pclk_fall = ~filt[DPS_PIN_CLK] & clk_prev;
  wire capture   = active & (edge_rise ? pclk_rise : pclk_fall);  // RULE_02

  // ==========================================================
  // Channel steering into the pair buffer
  logic                  half_done;
  logic [DPS_WORD_W-1:0] hold_a;
  logic                  buf_ready;
  logic                  buf_valid;
  logic                  ser_ready;
  dps_pair_t             buf_out;
  dps_pair_t             fill_data;
  wire                   fill_valid = capture & (~mode_single_in_dual_out | half_done);   // RULE_10
  wire                   dropped    = fill_valid & ~buf_ready;

  // Single mode leaves channel B quiet; split mode pairs two pixels
  assign fill_data.a = mode_single_in_dual_out ? hold_a : pix_a;                          // RULE_06
  assign fill_data.b = mode_dual_in_dual_out ? pix_b :                                  // RULE_11
                       mode_single_in_dual_out ? pix_a : '0;                              // RULE_09

  // First pixel of a pair waits in hold_a
  always_ff @(posedge i_sys_clk)
  begin
    if (dp_rst || !mode_single_in_dual_out)
    begin
      half_done <= 1'b0;
      hold_a    <= '0;
    end
    else if (capture)
    begin
      half_done <= ~half_done;  // RULE_10
      if (!half_done)
        hold_a <= pix_a;
    end
  end

  dps_pair_buf #(
    .W     (DPS_PAIR_W),
    .DEPTH (2)
  ) dps_pair_buf_i (
    .i_sys_clk (i_sys_clk),
    .i_rst     (dp_rst),
    .i_valid   (fill_valid),
    .o_ready   (buf_ready),
    .i_data    (fill_data),
    .o_valid   (buf_valid),
    .i_ready   (ser_ready),
    .o_data    (buf_out)
  );

  // ==========================================================
  // Lane serialiser, one bit per system clock, seven per pixel slot
  dps_ser_state_t        state;
  logic [2:0]            bit_cnt;
  dps_pair_t             shreg;
  logic                  dual_out;
  assign ser_ready = (state == DPS_IDLE) || (bit_cnt == DPS_LAST_BIT);
  wire                   ser_load  = buf_valid & ser_ready;

  // Pick bit k*7+cnt of a word for each lane
  function automatic logic [DPS_LANES-1:0] lane_bits(
    input logic [DPS_WORD_W-1:0] w,
    input logic [2:0]            cnt,
    input logic                  drop_top
  );
    logic [DPS_LANES-1:0] r;
    r = '0;
    for (int k = 0; k < DPS_LANES; k++)
      r[k] = w[k*DPS_BITS + int'(cnt)];
    if (drop_top)  // RULE_04
      r[DPS_LANES-1] = 1'b0;  // 18-bit colour leaves top lane idle
    return r;
  endfunction

  wire shifting = (state == DPS_SHIFT);
  wire [DPS_LANES-1:0] next_lane_a = shifting ? lane_bits(shreg.a, bit_cnt, depth_18) : '0;
  wire [DPS_LANES-1:0] next_lane_b = (shifting & dual_out) ?
                                     lane_bits(shreg.b, bit_cnt, depth_18) : '0;

  // Sequencer
  always_ff @(posedge i_sys_clk)
  begin
    if (dp_rst)
    begin
      state    <= DPS_IDLE;
      bit_cnt  <= 3'h0;
      shreg    <= '0;
      dual_out <= 1'b0;
    end
    else
    begin
      case (state)
        DPS_IDLE:
        begin
          if (ser_load)
          begin
            state    <= DPS_SHIFT;
            shreg    <= buf_out;
            dual_out <= ~mode_single_in_single_out;
            bit_cnt  <= 3'h0;
          end
        end
        DPS_SHIFT:
        begin
          if (bit_cnt == DPS_LAST_BIT)
          begin
            bit_cnt <= 3'h0;
            if (ser_load)
            begin
              shreg    <= buf_out;
              dual_out <= ~mode_single_in_single_out;
            end
            else
              state <= DPS_IDLE;
          end
          else
            bit_cnt <= bit_cnt + 3'h1;
        end
        default:
          state <= DPS_IDLE;
      endcase
    end
  end

  // Registered lane outputs, all low in sleep
  always_ff @(posedge i_sys_clk)
  begin
    if (dp_rst)
    begin
      o_chan_a_ser_lane <= '0;
      o_chan_b_ser_lane <= '0;
      o_chan_a_ser_clk  <= 1'b0;
      o_chan_b_ser_clk  <= 1'b0;
      o_swing_normal    <= 1'b0;
    end
    else
    begin
      o_chan_a_ser_lane <= next_lane_a;                                        // RULE_08
      o_chan_b_ser_lane <= next_lane_b;                                        // RULE_08
      o_chan_a_ser_clk  <= shifting & DPS_CLK_PATTERN[bit_cnt];                // RULE_08
      o_chan_b_ser_clk  <= shifting & dual_out & DPS_CLK_PATTERN[bit_cnt];
      o_swing_normal    <= filt[DPS_PIN_SWING];                                // RULE_05
    end
  end

  // ==========================================================
  // Activity counters for software
  logic [15:0] pix_cnt;
  logic [15:0] drop_cnt;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pix_cnt  <= DPS_CNT_RST;
      drop_cnt <= DPS_CNT_RST;
    end
    else
    begin
      if (capture)
        pix_cnt <= pix_cnt + DPS_CNT_ONE;
      if (dropped)
        drop_cnt <= drop_cnt + DPS_CNT_ONE;
    end
  end

  // ==========================================================
  // APB slave: zero wait, read data latched in the setup cycle
  wire        apb_setup = i_psel & ~i_penable;
  wire        apb_wr    = i_psel & i_penable & i_pwrite;
  wire        hit_ctrl  = (i_paddr == DPS_REG_CTRL);
  wire        hit_stat  = (i_paddr == DPS_REG_STATUS);
  wire        hit_pix   = (i_paddr == DPS_REG_PIXCNT);
  wire        hit_drop  = (i_paddr == DPS_REG_DROPS);
  wire        hit_any   = hit_ctrl | hit_stat | hit_pix | hit_drop;
  wire [31:0] status_w  = {22'h0, shifting, mode_rsvd, active, filt[DPS_PIN_SLEEPN],
                           filt[DPS_PIN_SWING], depth_18, edge_rise, 1'b0, mode};
  wire [31:0] rd_mux    = hit_ctrl ? {31'h0, soft_sleep} :
                          hit_stat ? status_w :
                          hit_pix  ? {16'h0, pix_cnt} :
                          hit_drop ? {16'h0, drop_cnt} : 32'h0000_0000;
  assign o_pready = 1'b1;  // Never stalls: every register answers at once

  // Register write and read capture
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      soft_sleep <= DPS_CTRL_RST[0];
      o_prdata   <= 32'h0000_0000;
      o_pslverr  <= 1'b0;
    end
    else
    begin
      if (apb_wr && hit_ctrl)
        soft_sleep <= i_pwdata[0];
      if (apb_setup)
      begin
        o_prdata  <= rd_mux;
        o_pslverr <= ~hit_any;
      end
    end
  end

  // ==========================================================
  // Checks
  AST_SLEEP_QUIET: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_03
    !active |=> (o_chan_a_ser_lane == '0) && !o_chan_a_ser_clk && !o_chan_b_ser_clk)
    else $error("Serial outputs not quiet in sleep");
  AST_EDGE_SEL: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_02
    capture |-> (edge_rise ? (filt[DPS_PIN_CLK] && !clk_prev) : (!filt[DPS_PIN_CLK] && clk_prev)))
    else $error("Capture on wrong pixel clock edge");
  AST_RSVD_FLAG: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_01
    mode_rsvd |-> status_w[8] && mode_single_in_single_out)
    else $error("Reserved mode not flagged");
  AST_DEPTH18: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_04
    depth_18 && $past(depth_18) && active |-> !o_chan_a_ser_lane[DPS_LANES-1])
    else $error("Top lane active in 18-bit mode");
  AST_SWING: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_05
    active && $past(active) |-> o_swing_normal == $past(filt[DPS_PIN_SWING]))
    else $error("Swing output does not follow strap");
  AST_SYNC_POS: assert property (@(posedge i_sys_clk) disable iff (i_rst)  // RULE_06
    fill_valid && !mode_single_in_dual_out |->
      fill_data.a[DPS_DVAL_POS:DPS_HSYNC_POS] == pix_a[DPS_DVAL_POS:DPS_HSYNC_POS])
    else $error("Sync bits moved in channel A word");
  AST_SLOT_LEN: assert property (@(posedge i_sys_clk) disable iff (dp_rst)  // RULE_08
    $rose(shifting) |-> shifting[*7])
    else $error("Pixel slot shorter than seven bits");
  AST_SINGLE_IN_SINGLE_OUT_B: assert property (@(posedge i_sys_clk) disable iff (dp_rst)  // RULE_09
    fill_valid && mode_single_in_single_out |-> fill_data.b == '0)
    else $error("Channel B fed in single mode");
  AST_SINGLE_IN_DUAL_OUT_PAIR: assert property (@(posedge i_sys_clk) disable iff (dp_rst)  // RULE_10
    capture && mode_single_in_dual_out && !half_done |-> !fill_valid ##1 half_done)
    else $error("Split mode pushed an unpaired pixel");
  AST_DUAL_IN_DUAL_OUT_MAP: assert property (@(posedge i_sys_clk) disable iff (dp_rst)  // RULE_11
    fill_valid && mode_dual_in_dual_out |-> fill_data.a == pix_a && fill_data.b == pix_b)
    else $error("Dual mode channel mapping wrong");
  AST_DEFAULTS: assert property (@(posedge i_sys_clk)  // RULE_12
    $past(i_rst) |-> mode == DPS_MODE_SINGLE_IN_SINGLE_OUT && !edge_rise && !active && !depth_18)
    else $error("Defaults after reset not low");

endmodule

// File: dv/dps_far_model.sv
/*
  Far-side models: gated pixel clock source and one lane collector.
  Assumes lanes and clock lanes change on rising i_sys_clk edges.
*/
// ==========================================
// Pixel clock source
module dps_pix_src (
  input  wire logic i_run,  // Toggle while high
  input  wire logic i_idle, // Level parked between frames
  output logic      o_clk   // Pixel clock pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Parks at the idle level, so a frame never opens on a capture edge
  initial
  begin
    o_clk = 1'b0;
    #1.3;
    forever
    begin
      #32;
      if (i_run || (o_clk !== i_idle))
        o_clk = ~o_clk;
    end
  end
endmodule

// ==========================================
// Lane collector
module dps_lane_sink (
  input  wire logic                          i_sys_clk,  // System clock
  input  wire logic [dps_pkg::DPS_LANES-1:0] i_lane,     // Serial data lanes
  input  wire logic                          i_clk_lane, // Serial clock lane
  output logic [dps_pkg::DPS_WORD_W-1:0]     o_word,     // Rebuilt word
  output logic                               o_got,      // Word complete
  output logic                               o_bad       // Clock lane off shape
);
  timeunit 1ns;
  timeprecision 100ps;
  import dps_pkg::*;
  logic [2:0] idx  = 3'h0; // Bit slot, 0 when idle
  logic       prev = 1'b0; // Clock lane last cycle
  // A frame opens on a rise of the clock lane out of idle
  always @(posedge i_sys_clk)
  begin
    prev  <= i_clk_lane;
    o_got <= 1'b0;
    o_bad <= 1'b0;
    if ((idx != 3'h0) || (i_clk_lane && !prev))
    begin
      for (int k = 0; k < DPS_LANES; k++)
        o_word[k*DPS_BITS+idx] <= i_lane[k];
      o_bad <= (i_clk_lane !== DPS_CLK_PATTERN[idx]);
      idx   <= (idx == DPS_LAST_BIT) ? 3'h0 : idx + 3'h1;
      o_got <= (idx == DPS_LAST_BIT);
    end
  end
endmodule

// File: dv/dps_serializer_ctl_test.sv
/*
  Self-checking bench of the serializer control block.
  Assumes zero-wait APB, registered lanes and the far-side models.
*/
module dps_serializer_ctl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import dps_pkg::*;
  logic                  sys_clk, rst, pix_run, pixel_clk, mode_lo, mode_hi, edge_sel;
  logic                  sleep_n, depth, swing, clk_a, clk_b, swing_normal, active;
  logic                  psel, penable, pwrite, pready, pslverr, err;
  logic                  got_a, got_b, bad_a, bad_b;
  logic [3:0]            lane_a, lane_b;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [DPS_WORD_W-1:0] pix_a, pix_b, word_a, word_b;
  logic [DPS_WORD_W-1:0] exp_a[$], exp_b[$];
  integer                seed = 32'hdb2503e6;
  int                    fails, cmp_count, cycles;

  // ==========================================
  // Clock, hang guard, instances
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Run needs about a thousand cycles; a hang ends the run as a mismatch
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      final_report();
    end
  end
  dps_serializer_ctl dps_serializer_ctl_i (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_pixel_clk(pixel_clk),
    .i_op_mode_sel_lo(mode_lo), .i_op_mode_sel_hi(mode_hi),
    .i_capture_edge_sel(edge_sel), .i_sleep_n(sleep_n), .i_color_depth_sel(depth),
    .i_out_swing_sel(swing), .i_chan_a_pixel_in(pix_a), .i_chan_b_pixel_in(pix_b),
    .o_chan_a_ser_lane(lane_a), .o_chan_a_ser_clk(clk_a), .o_chan_b_ser_lane(lane_b),
    .o_chan_b_ser_clk(clk_b), .o_swing_normal(swing_normal), .o_active(active),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  dps_pix_src dps_pix_src_i (.i_run(pix_run), .i_idle(edge_sel), .o_clk(pixel_clk));
  dps_lane_sink dps_lane_sink_a_i (.i_sys_clk(sys_clk), .i_lane(lane_a),
    .i_clk_lane(clk_a), .o_word(word_a), .o_got(got_a), .o_bad(bad_a));
  dps_lane_sink dps_lane_sink_b_i (.i_sys_clk(sys_clk), .i_lane(lane_b),
    .i_clk_lane(clk_b), .o_word(word_b), .o_got(got_b), .o_bad(bad_b));

  // ==========================================
  // Compare and expectation helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // 18-bit pixels leave the top lane low
  function automatic logic [DPS_WORD_W-1:0] exp_word(input logic [DPS_WORD_W-1:0] w);
    exp_word = depth ? {7'h00, w[20:0]} : w;
  endfunction
  task automatic pop_chk(ref logic [DPS_WORD_W-1:0] q[$], input logic [DPS_WORD_W-1:0] w);
    if (q.size() == 0)
      chk({4'h0, w}, 32'hFFFF_FFFF);
    else
      chk({4'h0, w}, {4'h0, q.pop_front()});
  endtask
  // Every rebuilt word must be the next one expected on that channel
  always @(posedge sys_clk)
  begin
    if (got_a === 1'b1) pop_chk(exp_a, word_a);
    if (got_b === 1'b1) pop_chk(exp_b, word_b);
    if ((bad_a === 1'b1) || (bad_b === 1'b1)) chk(32'h1, 32'h0);
  end

  // ==========================================
  // APB master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, x);
    chk(err, xe);
  endtask

  // ==========================================
  // Pixel stream: words change on the edge opposite to capture
  task automatic stream(input int n, input bit quiet);
    logic [DPS_WORD_W-1:0] a, b;
    bit                    ph = 1'b0;
    @(posedge sys_clk);
    pix_run <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      a = DPS_WORD_W'($random(seed));
      b = DPS_WORD_W'($random(seed));
      if (edge_sel) @(negedge pixel_clk);
      else @(posedge pixel_clk);
      @(posedge sys_clk);
      pix_a   <= a;
      pix_b   <= b;
      pix_run <= (i != n - 1);
      if (quiet) ;
      else if ({mode_hi, mode_lo} == DPS_MODE_DUAL_IN_DUAL_OUT)
      begin
        exp_a.push_back(exp_word(a));
        exp_b.push_back(exp_word(b));
      end
      else if (({mode_hi, mode_lo} == DPS_MODE_SINGLE_IN_DUAL_OUT) && ph)
        exp_b.push_back(exp_word(a));
      else
        exp_a.push_back(exp_word(a));
      ph = ~ph;
    end
    repeat (40) @(posedge sys_clk);
    chk(32'(exp_a.size() + exp_b.size()), 32'h0);
  endtask
  // Straps change only in sleep; then wake, check status and stream
  task automatic setup(input logic [1:0] m, input logic e, input logic d, input logic s);
    logic [31:0] cnt0;
    int          n;
    @(posedge sys_clk);
    sleep_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({active, swing_normal, lane_a, clk_a, lane_b, clk_b}, 32'h0);
    {mode_hi, mode_lo} <= m;
    edge_sel <= e;
    depth    <= d;
    swing    <= s;
    repeat (20) @(posedge sys_clk);
    sleep_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk({active, swing_normal}, {1'b1, s});
    rd_chk(DPS_REG_STATUS, {22'h0, 1'b0, m == DPS_MODE_RSVD, 2'b11, s, d, e, 1'b0, m}, 0);
    apb(1'b0, DPS_REG_PIXCNT, 32'h0, cnt0, err);
    n = 2 + 2 * ($unsigned($random(seed)) % 3);
    stream(n, 1'b0);
    rd_chk(DPS_REG_PIXCNT, {16'h0, cnt0[15:0] + 16'(n)}, 0);
  endtask

  // ==========================================
  // Main sequence
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if ((fails == 0) && (cmp_count > 0))
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {rst, pix_run, mode_lo, mode_hi, edge_sel, sleep_n, depth, swing} = 8'h80;
    {psel, penable, pwrite, paddr, pwdata, pix_a, pix_b} = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    // Straps left low: asleep, single/single, 24-bit, low swing
    chk({active, swing_normal, lane_a, lane_b}, 32'h0);
    rd_chk(DPS_REG_STATUS, 32'h0, 0);
    rd_chk(DPS_REG_CTRL, DPS_CTRL_RST, 0);
    setup(DPS_MODE_SINGLE_IN_SINGLE_OUT, 0, 0, 0);
    setup(DPS_MODE_SINGLE_IN_DUAL_OUT, 1, 0, 1);
    setup(DPS_MODE_DUAL_IN_DUAL_OUT, 0, 1, 1);
    setup(DPS_MODE_SINGLE_IN_DUAL_OUT, 0, 1, 0);
    setup(DPS_MODE_DUAL_IN_DUAL_OUT, 1, 0, 0);
    setup(DPS_MODE_RSVD, 1, 1, 1);
    // Soft sleep: pixels ignored, lanes stay quiet
    apb(1'b1, DPS_REG_CTRL, 32'h1, rd, err);
    @(negedge sys_clk);
    chk(active, 0);
    rd_chk(DPS_REG_CTRL, 32'h1, 0);
    stream(2, 1'b1);
    apb(1'b1, DPS_REG_CTRL, 32'h0, rd, err);
    // Unmapped place: error, zero data, write lost
    apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, err);
    chk(err, 1);
    rd_chk(8'h10, 32'h0, 1);
    rd_chk(DPS_REG_DROPS, 32'h0, 0);
    final_report();
  end
endmodule
